// ==== i2c_master_model.sv ====
// Serial bus master that programs, reads back and erases pages
// Assumes the bench pulls sda up and feeds back the wired level
module i2c_master_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Half link period of 200 ns
    task automatic half();
        repeat (4) @(negedge clk);
    endtask : half

    // Also serves as repeated start
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
        half();
    endtask : start

    // Ends every transfer and launches write or erase cycles
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
        half();
    endtask : stop

    task automatic xbit(input logic b, output logic r);
        sda_low = !b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask : xbit

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
        end
        xbit(1'b1, r);
        ack = !r;
    endtask : wbyte

    // Master acknowledges to continue, not on the last byte
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, d[i]);
        end
        xbit(!mack, r);
    endtask : rbyte
endmodule : i2c_master_model

// ==== i2c_nvm_target.sv ====
// Serial target that programs, reads back and erases 16-byte nonvolatile pages
// Assumes scl, sda and the code pins are asynchronous; store and registers are on clk
//
// How it works
// - Each write to a page block programs at most one 16-byte page.
// - Control code settings load defaults on reset and reload from stored values only on reset command.
// - Control byte, word address and each of sixteen data bytes are acknowledged.
// - Stop after page data starts a self-timed write of at most 20 ms.
// - Register data stays reachable while a write or erase cycle runs.
// - Repeated start aborts the write but keeps the loaded word address.
// - Read control byte is acknowledged, then bytes go out with address advancing.
// - The erase register sits at word address e3 and takes one byte.
// - Trigger bit 7 starts a self-timed page erase of at most 20 ms.
// - Bit 4 picks config or emulated area, bits 3 to 0 pick the page.
// - Device address, erase address and erase byte are all acknowledged.
// - The erase cycle starts only at the stop that ends the erase write.
// - The erase trigger bit clears itself when the erase completes.
// - Each control code bit comes from a pin or register, per select bit.
// - After reset the control code is 0001.
// - Next three bits give the block address, last bit selects read.
// - A control byte that matches the control code is acknowledged for block 000, or for 010 and 011 when not busy.
// - Block 010 reaches config pages, block 011 the emulated pages.
`include "nvm_map.svh"

module i2c_nvm_target #(
    parameter int WR_CYCLES = `T_WR_CYCLES,
    parameter int ER_CYCLES = `T_ER_CYCLES,
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire logic [3:0]        code_pins,
    input  wire logic              reset_cmd,
    input  wire logic [3:0]        nv_code,
    input  wire logic [3:0]        nv_code_src,
    output logic                   reg_wr_en,
    output logic [7:0]             reg_wr_addr,
    output logic [7:0]             reg_wr_data,
    output logic [7:0]             reg_rd_addr,
    input  wire logic [7:0]        reg_rd_data,
    output logic [8:0]             store_rd_addr,
    input  wire logic [7:0]        store_rd_data,
    output logic                   store_wr_en,
    output nvm_pkg::store_wr_s     store_wr,
    input  wire logic              store_wr_ready,
    output logic                   store_erase,
    output logic [4:0]             store_erase_page,
    output logic                   nvm_busy
);
    localparam logic [18:0] WR_LAST = 19'(WR_CYCLES - 1);
    localparam logic [18:0] ER_LAST = 19'(ER_CYCLES - 1);

    nvm_pkg::target_s   q;
    nvm_pkg::target_s   d;
    nvm_pkg::store_wr_s push_data;
    logic               push;
    logic               flush;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic               fifo_out_ready;
    logic [3:0]         eff_code;
    logic               start_det;
    logic               stop_det;
    logic               scl_rise;
    logic               scl_fall;
    logic [7:0]         rd_byte;
    logic               nvm_blk;
    logic [2:0]         ctrl_blk;
    logic               ctrl_ok;

    for (genvar i = 0; i < 4; i++) begin : g_code
        assign eff_code[i] = q.src_q[i] ? q.pin_s2[i] : q.code_q[i];
    end

    assign start_det = q.scl_s2 && q.scl_s3 && q.sda_s3 && !q.sda_s2;
    assign stop_det  = q.scl_s2 && q.scl_s3 && !q.sda_s3 && q.sda_s2;
    assign scl_rise  = q.scl_s2 && !q.scl_s3;
    assign scl_fall  = !q.scl_s2 && q.scl_s3;
    assign rd_byte   = (q.blk == `BLK_REGS) ? reg_rd_data : store_rd_data;
    assign nvm_blk   = (q.blk == `BLK_CFG) || (q.blk == `BLK_EEPROM);
    assign ctrl_blk  = q.shreg[3:1];
    assign ctrl_ok   = (q.shreg[7:4] == eff_code) && ((ctrl_blk == `BLK_REGS) ||
                       (((ctrl_blk == `BLK_CFG) || (ctrl_blk == `BLK_EEPROM)) && !q.busy));

    assign push_data.addr = {q.blk[0], q.addr};
    assign push_data.data = q.shreg;
    assign fifo_out_ready = q.busy && !q.erasing && store_wr_ready;
    assign store_wr_en    = fifo_out_valid && fifo_out_ready;

    page_fifo #(
        .WIDTH ($bits(nvm_pkg::store_wr_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .flush     (flush),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (store_wr)
    );

    always_comb begin
        d           = q;
        push        = 1'b0;
        flush       = 1'b0;
        d.scl_s1    = scl_in;
        d.scl_s2    = q.scl_s1;
        d.scl_s3    = q.scl_s2;
        d.sda_s1    = sda_in;
        d.sda_s2    = q.sda_s1;
        d.sda_s3    = q.sda_s2;
        d.pin_s1    = code_pins;
        d.pin_s2    = q.pin_s1;
        d.reg_wr    = 1'b0;
        d.store_erase = 1'b0;
        if (reset_cmd) begin
            d.code_q = nv_code;
            d.src_q  = nv_code_src;
        end
        if (q.busy) begin
            if (q.tmr != (q.erasing ? ER_LAST : WR_LAST)) begin
                d.tmr = q.tmr + 19'h00001;
            end
            if (q.erasing && q.tmr == ER_LAST) begin
                d.busy    = 1'b0;
                d.erasing = 1'b0;
                d.erase_q[`ERASE_TRIG_BIT] = 1'b0;
            end else if (!q.erasing && q.tmr == WR_LAST && !fifo_out_valid) begin
                d.busy = 1'b0;
            end
        end
        if (start_det) begin
            flush     = q.wr_pend;
            d.wr_pend = 1'b0;
            d.er_pend = 1'b0;
            d.st      = nvm_pkg::ST_CTRL;
            d.bitcnt  = 4'h0;
            d.nbytes  = 5'h00;
            d.oe      = 1'b0;
        end else if (stop_det) begin
            d.st      = nvm_pkg::ST_IDLE;
            d.oe      = 1'b0;
            d.wr_pend = 1'b0;
            d.er_pend = 1'b0;
            if (q.wr_pend) begin
                d.busy    = 1'b1;
                d.erasing = 1'b0;
                d.tmr     = 19'h00000;
            end else if (q.er_pend && q.erase_q[`ERASE_TRIG_BIT] && !q.busy) begin
                d.busy        = 1'b1;
                d.erasing     = 1'b1;
                d.tmr         = 19'h00000;
                d.store_erase = 1'b1;
            end
        end else begin
            case (q.st)
                nvm_pkg::ST_CTRL, nvm_pkg::ST_WADDR, nvm_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        d.shreg  = {q.shreg[6:0], q.sda_s2};
                        d.bitcnt = q.bitcnt + 4'h1;
                    end else if (scl_fall && q.bitcnt == `BYTE_BITS) begin
                        d.bitcnt = 4'h0;
                        if (q.st == nvm_pkg::ST_CTRL) begin
                            d.blk = ctrl_blk;
                            d.rw  = q.shreg[0];
                            d.oe  = ctrl_ok;
                            d.st  = ctrl_ok ? nvm_pkg::ST_ACK_CTRL : nvm_pkg::ST_SKIP;
                        end else if (q.st == nvm_pkg::ST_WADDR) begin
                            d.addr = q.shreg;
                            d.oe   = 1'b1;
                            d.st   = nvm_pkg::ST_ACK_WADDR;
                        end else begin
                            d.st = nvm_pkg::ST_ACK_WDATA;
                            d.oe = 1'b1;
                            if (nvm_blk) begin
                                if (q.nbytes != `PAGE_BYTES) begin
                                    if (fifo_in_ready) begin
                                        push      = 1'b1;
                                        d.nbytes  = q.nbytes + 5'h01;
                                        d.wr_pend = 1'b1;
                                        d.addr    = {q.addr[7:4], q.addr[3:0] + 4'h1};
                                    end else begin
                                        d.oe = 1'b0;
                                    end
                                end
                            end else begin
                                if (q.addr == `ERASE_REG_ADDR) begin
                                    d.erase_q = q.shreg;
                                    d.er_pend = 1'b1;
                                end else begin
                                    d.reg_wr    = 1'b1;
                                    d.reg_waddr = q.addr;
                                    d.reg_wdata = q.shreg;
                                end
                                d.addr = q.addr + 8'h01;
                            end
                        end
                    end
                end
                nvm_pkg::ST_ACK_CTRL: begin
                    if (scl_fall) begin
                        if (q.rw) begin
                            d.shreg  = rd_byte;
                            d.oe     = !rd_byte[7];
                            d.bitcnt = 4'h0;
                            d.st     = nvm_pkg::ST_RDATA;
                        end else begin
                            d.oe = 1'b0;
                            d.st = nvm_pkg::ST_WADDR;
                        end
                    end
                end
                nvm_pkg::ST_ACK_WADDR, nvm_pkg::ST_ACK_WDATA: begin
                    if (scl_fall) begin
                        d.oe = 1'b0;
                        d.st = nvm_pkg::ST_WDATA;
                    end
                end
                nvm_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        d.bitcnt = q.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.bitcnt == `BYTE_BITS) begin
                            d.oe   = 1'b0;
                            d.addr = q.addr + 8'h01;
                            d.st   = nvm_pkg::ST_MACK;
                        end else begin
                            d.shreg = {q.shreg[6:0], 1'b0};
                            d.oe    = !q.shreg[6];
                        end
                    end
                end
                nvm_pkg::ST_MACK: begin
                    if (scl_rise && q.sda_s2) begin
                        d.st = nvm_pkg::ST_SKIP;
                    end else if (scl_fall) begin
                        d.shreg  = rd_byte;
                        d.oe     = !rd_byte[7];
                        d.bitcnt = 4'h0;
                        d.st     = nvm_pkg::ST_RDATA;
                    end
                end
                nvm_pkg::ST_IDLE, nvm_pkg::ST_SKIP: begin
                    d.oe = 1'b0;
                end
                default: begin
                    d.st = nvm_pkg::ST_IDLE;
                    d.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q        <= '0;
            q.st     <= nvm_pkg::ST_IDLE;
            q.code_q <= `CODE_DEFAULT;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.scl_s3 <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_s3 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sda_out          = 1'b0;
    assign sda_oe           = q.oe;
    assign reg_wr_en        = q.reg_wr;
    assign reg_wr_addr      = q.reg_waddr;
    assign reg_wr_data      = q.reg_wdata;
    assign reg_rd_addr      = q.addr;
    assign store_rd_addr    = {q.blk[0], q.addr};
    assign store_erase      = q.store_erase;
    assign store_erase_page = q.erase_q[`ERASE_REGION_BIT:0];
    assign nvm_busy         = q.busy;

    sequence stop_seen_s;
        $past(stop_det);
    endsequence

    sequence erase_armed_s;
        $past(q.er_pend) && $past(q.erase_q[`ERASE_TRIG_BIT]);
    endsequence

    busy_nack_a: assert property (@(posedge clk) disable iff (srst)
        (q.st == nvm_pkg::ST_ACK_CTRL && q.busy) |-> !nvm_blk)
        else $error("Nonvolatile control byte acknowledged while busy");
    code_default_a: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> (q.code_q == `CODE_DEFAULT))
        else $error("Control code not default after reset");
    code_reload_a: assert property (@(posedge clk) disable iff (srst)
        $changed(q.code_q) |-> $past(reset_cmd) || $past(srst))
        else $error("Control code changed without reset command");
    erase_on_stop_a: assert property (@(posedge clk) disable iff (srst)
        $rose(q.erasing) |-> stop_seen_s and erase_armed_s and store_erase)
        else $error("Erase started without stop after erase write");
    erase_clear_a: assert property (@(posedge clk) disable iff (srst)
        $fell(q.erasing) |-> !q.erase_q[`ERASE_TRIG_BIT] && !q.busy)
        else $error("Erase trigger not cleared at completion");
    erase_len_a: assert property (@(posedge clk) disable iff (srst)
        (q.erasing && q.tmr == ER_LAST) |=> !q.erasing)
        else $error("Erase cycle overran its time");
    erase_page_a: assert property (@(posedge clk) disable iff (srst)
        store_erase |-> (store_erase_page == $past(q.erase_q[4:0])))
        else $error("Erase page differs from erase register");
    write_on_stop_a: assert property (@(posedge clk) disable iff (srst)
        ($rose(q.busy) && !q.erasing) |-> stop_seen_s and $past(q.wr_pend))
        else $error("Write cycle started without stop after page data");
    write_len_a: assert property (@(posedge clk) disable iff (srst)
        (q.busy && !q.erasing && q.tmr == WR_LAST && !fifo_out_valid) |=> !q.busy)
        else $error("Write cycle overran its time");
    read_advance_a: assert property (@(posedge clk) disable iff (srst)
        (q.st == nvm_pkg::ST_RDATA && scl_fall && q.bitcnt == `BYTE_BITS)
        |=> (q.addr == $past(q.addr) + 8'h01))
        else $error("Read address did not advance after a byte");
    addr_keep_a: assert property (@(posedge clk) disable iff (srst)
        start_det |=> (q.addr == $past(q.addr)))
        else $error("Repeated start lost the word address");
    page_limit_a: assert property (@(posedge clk) disable iff (srst)
        push |-> (q.nbytes < `PAGE_BYTES) && !q.busy)
        else $error("Data byte past page end was buffered");

endmodule : i2c_nvm_target

// ==== nvm_map.svh ====
// Offsets, field positions, reset values and timing counts of the page engine
// Assumes inclusion by the package and the target module only
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

`define ERASE_REG_ADDR   8'he3
`define ERASE_TRIG_BIT   7
`define ERASE_REGION_BIT 4
`define CODE_DEFAULT     4'h1
`define BLK_REGS         3'h0
`define BLK_CFG          3'h2
`define BLK_EEPROM       3'h3
`define PAGE_BYTES       5'h10
`define BYTE_BITS        4'h8
`define T_WR_MS          20
`define T_ER_MS          20
`define CLK_HZ           20000000
`define T_WR_CYCLES      (`T_WR_MS * (`CLK_HZ / 1000))
`define T_ER_CYCLES      (`T_ER_MS * (`CLK_HZ / 1000))

`endif

// ==== nvm_pkg.sv ====
// Types shared by the page engine and its buffer
// Assumes nvm_map.svh is on the include path
`include "nvm_map.svh"

package nvm_pkg;

    typedef enum logic [9:0] {
        ST_IDLE      = 10'h001,
        ST_CTRL      = 10'h002,
        ST_ACK_CTRL  = 10'h004,
        ST_WADDR     = 10'h008,
        ST_ACK_WADDR = 10'h010,
        ST_WDATA     = 10'h020,
        ST_ACK_WDATA = 10'h040,
        ST_RDATA     = 10'h080,
        ST_MACK      = 10'h100,
        ST_SKIP      = 10'h200
    } link_state_e;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
    } store_wr_s;

    typedef struct packed {
        link_state_e st;
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_s3;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_s3;
        logic [3:0]  pin_s1;
        logic [3:0]  pin_s2;
        logic [3:0]  bitcnt;
        logic [7:0]  shreg;
        logic        rw;
        logic [2:0]  blk;
        logic [7:0]  addr;
        logic [4:0]  nbytes;
        logic [7:0]  erase_q;
        logic [3:0]  code_q;
        logic [3:0]  src_q;
        logic        oe;
        logic        busy;
        logic        erasing;
        logic [18:0] tmr;
        logic        wr_pend;
        logic        er_pend;
        logic        reg_wr;
        logic [7:0]  reg_waddr;
        logic [7:0]  reg_wdata;
        logic        store_erase;
    } target_s;

endpackage : nvm_pkg

// ==== page_fifo.sv ====
// Page data buffer between the link and the nonvolatile store
// Assumes one clock; read data leave from a register
module page_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             empty;
    logic             full;
    logic             push;
    logic             pop;

    assign empty     = (wr_q == rd_q);
    assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_ready  = !full;
    assign push      = in_valid && !full;
    assign pop       = !empty && (!out_valid || out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || flush) begin
            wr_q      <= '0;
            rd_q      <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q      <= rd_q + 1'b1;
                out_data  <= mem_q[rd_q[AW-1:0]];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

endmodule : page_fifo

// ==== tb_i2c_nvm_target.sv ====
// Testbench for the page program, read back and erase target
// Assumes the master model and a behavioural store and register file
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module tb_i2c_nvm_target;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WR = 2000;
    localparam int ER = 2000;

    logic               clk, srst, scl, sda, sda_low, sda_out, sda_oe, reset_cmd;
    logic               reg_wr_en, store_wr_en, store_erase, nvm_busy, ack;
    logic [3:0]         code_pins, nv_code, nv_code_src;
    logic [7:0]         reg_wr_addr, reg_wr_data, reg_rd_addr, rd, d;
    logic [8:0]         store_rd_addr;
    logic [4:0]         store_erase_page, erpg;
    nvm_pkg::store_wr_s store_wr;
    logic [7:0]         mem [512];
    logic [7:0]         regs [256];
    int                 err_count, check_count, nwr, ner;

    // Pull-up on the data line
    assign sda = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

    i2c_master_model i_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    i2c_nvm_target #(.WR_CYCLES(WR), .ER_CYCLES(ER), .FIFO_DEPTH(32)) i_dut (
        .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .code_pins(code_pins), .reset_cmd(reset_cmd), .nv_code(nv_code),
        .nv_code_src(nv_code_src), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(regs[reg_rd_addr]),
        .store_rd_addr(store_rd_addr), .store_rd_data(mem[store_rd_addr]),
        .store_wr_en(store_wr_en), .store_wr(store_wr), .store_wr_ready(1'b1),
        .store_erase(store_erase), .store_erase_page(store_erase_page), .nvm_busy(nvm_busy));

    // Behavioural store and register file
    always @(posedge clk) begin
        if (store_wr_en) begin
            mem[store_wr.addr] <= store_wr.data;
            nwr++;
        end
        if (store_erase) begin
            ner++;
            erpg <= store_erase_page;
        end
        if (reg_wr_en) begin
            regs[reg_wr_addr] <= reg_wr_data;
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic probe(input logic [7:0] b, input logic exp);
        i_master.start();
        i_master.wbyte(b, ack);
        `CHK(ack, exp)
        i_master.stop();
    endtask : probe

    task automatic wait_idle();
        for (int i = 0; i < 3000 && nvm_busy; i++) begin
            @(negedge clk);
        end
        `CHK(nvm_busy, 1'b0)
    endtask : wait_idle

    initial begin
        repeat (60000) @(negedge clk);
        err_count++;
        conclude();
    end

    initial begin
        srst = 1'b1;
        reset_cmd = 1'b0;
        code_pins = 4'h2;
        nv_code = 4'h5;
        nv_code_src = 4'h3;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        probe(8'h24, 1'b0);
        probe(8'h12, 1'b0);
        probe(8'h10, 1'b1);
        // Page write of 17 bytes at a page boundary
        i_master.start();
        i_master.wbyte(8'h14, ack);
        `CHK(ack, 1'b1)
        i_master.wbyte(8'h50, ack);
        `CHK(ack, 1'b1)
        for (int n = 0; n < 17; n++) begin
            i_master.wbyte(8'ha0 + n[7:0], ack);
            `CHK(ack, 1'b1)
        end
        i_master.stop();
        `CHK(nvm_busy, 1'b1)
        probe(8'h14, 1'b0);
        // Register write while the cycle runs
        i_master.start();
        i_master.wbyte(8'h10, ack);
        `CHK(ack, 1'b1)
        i_master.wbyte(8'h20, ack);
        i_master.wbyte(8'h5a, ack);
        i_master.stop();
        `CHK(regs[8'h20], 8'h5a)
        // Register read back while the cycle runs
        i_master.start();
        i_master.wbyte(8'h10, ack);
        i_master.wbyte(8'h20, ack);
        i_master.start();
        i_master.wbyte(8'h11, ack);
        `CHK(ack, 1'b1)
        i_master.rbyte(1'b0, rd);
        i_master.stop();
        `CHK(rd, 8'h5a)
        `CHK(nvm_busy, 1'b1)
        wait_idle();
        `CHK(nwr, 16)
        for (int n = 0; n < 16; n++) begin
            `CHK(mem[9'h050 + n[8:0]], 8'ha0 + n[7:0])
        end
        // Random sequential read
        i_master.start();
        i_master.wbyte(8'h14, ack);
        i_master.wbyte(8'h52, ack);
        i_master.start();
        i_master.wbyte(8'h15, ack);
        `CHK(ack, 1'b1)
        for (int n = 0; n < 3; n++) begin
            i_master.rbyte(n < 2, rd);
            `CHK(rd, 8'ha2 + n[7:0])
        end
        i_master.stop();
        // Erase register, trigger clear then set
        for (int k = 0; k < 2; k++) begin
            d = k ? 8'h93 : 8'h0c;
            i_master.start();
            i_master.wbyte(8'h10, ack);
            i_master.wbyte(8'he3, ack);
            `CHK(ack, 1'b1)
            i_master.wbyte(d, ack);
            `CHK(ack, 1'b1)
            `CHK(ner, 0)
            i_master.stop();
            `CHK(ner, k)
        end
        `CHK(erpg, 5'h13)
        `CHK(nvm_busy, 1'b1)
        wait_idle();
        // Control code from pins and register after a reload
        reset_cmd = 1'b1;
        @(negedge clk);
        reset_cmd = 1'b0;
        probe(8'h60, 1'b1);
        probe(8'h10, 1'b0);
        conclude();
    end
endmodule : tb_i2c_nvm_target
